// >>> pkg/dmaxp_pkg.sv
// Shared constants and types for the DMA channel with extended addressing and pattern match.
package dmaxp_pkg;

    // Register byte offsets on the AXI4-Lite bus.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ECON = 8'h04;
    localparam logic [7:0] OFS_INT = 8'h08;
    localparam logic [7:0] OFS_SSA = 8'h0c;
    localparam logic [7:0] OFS_DSA = 8'h10;
    localparam logic [7:0] OFS_SSIZ = 8'h14;
    localparam logic [7:0] OFS_DSIZ = 8'h18;
    localparam logic [7:0] OFS_SPTR = 8'h1c;
    localparam logic [7:0] OFS_DPTR = 8'h20;
    localparam logic [7:0] OFS_CSIZ = 8'h24;
    localparam logic [7:0] OFS_CPTR = 8'h28;
    localparam logic [7:0] OFS_PAT = 8'h2c;

    // Bit positions in the channel control register.
    localparam int unsigned CTRL_XM = 3;
    localparam int unsigned CTRL_AEN = 4;
    localparam int unsigned CTRL_EN = 7;
    // Bit positions in the event control register.
    localparam int unsigned ECON_PATTERN_MATCH_ENABLE = 5;
    localparam int unsigned ECON_ABORT = 6;
    localparam int unsigned ECON_FORCE = 7;
    // Bit positions in the channel interrupt (flag) register.
    localparam int unsigned INT_AEF = 0;
    localparam int unsigned INT_TAF = 1;
    localparam int unsigned INT_BCF = 3;

    // Values after reset.
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    // Byte counts that a size field of zero stands for.
    localparam logic [8:0] NORM_MAX = 9'h100;
    localparam logic [16:0] EXT_MAX = 17'h1_0000;
    // AXI response codes.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum {ST_IDLE, ST_READ, ST_WRITE} dmaxp_state_e;

    // Request from the channel to the system bus.
    typedef struct packed {
        logic req;
        logic we;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [3:0] be;
    } dmaxp_mreq_s;

    // Answer from the system bus.
    typedef struct packed {
        logic ack;
        logic err;
        logic [31:0] rdata;
    } dmaxp_mrsp_s;

endpackage

// >>> src/dmaxp_channel.sv
// One DMA channel with extended addressing and pattern-match termination, AXI4-Lite registers.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Control bit 3 selects extended addressing; clear selects normal addressing.
// - Extended mode moves up to 64 Kbytes per block.
// - Extended size is source size high byte joined with destination size low byte.
// - Extended pointer is both pointers joined; destination read shows all 16 bits.
// - Extended mode moves a whole block per start; cell registers are ignored.
// - Pattern termination only acts while event control bit 5 is set.
// - Every written byte is compared with the pattern; a match ends the transfer.
// - A match sets block-complete flag and clears enable unless auto-enable is set.
// - The pattern data register holds the comparison value.
// - Pattern matching works identically in normal and extended addressing.
// - Force-start bit 7 of event control starts an enabled channel.
// - The block-complete flag stays set until software clears it.
// - Transfers start only while the channel-enable bit 7 is set; clearing it does not stop a cell under way.
// - A pattern match resets both pointers whatever auto-enable says.
// - With auto-enable, block completion or match keeps the channel enabled.
// - Abort or termination first completes the transaction already under way.
module dmaxp_channel (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels.
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // System event that starts a cell transfer.
    input wire logic start_event,
    // System bus master port.
    output dmaxp_pkg::dmaxp_mreq_s mreq,
    input wire dmaxp_pkg::dmaxp_mrsp_s mrsp
);

    logic [7:0] ctrl, econ, flags, ssiz, dsiz, csiz, sptr, dptr, cptr, pat, rbyte;
    logic [31:0] ssa, dsa;
    logic [16:0] bcnt;
    logic start_pend, abort_pend;
    dmaxp_pkg::dmaxp_state_e state;
    logic aw_hold, w_hold;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [7:0] next_ctrl, next_econ, next_flags, next_ssiz, next_dsiz, next_csiz;
    logic [7:0] next_sptr, next_dptr, next_cptr, next_pat, next_rbyte;
    logic [31:0] next_ssa, next_dsa;
    logic [16:0] next_bcnt;
    logic next_start_pend, next_abort_pend;
    dmaxp_pkg::dmaxp_state_e next_state;
    dmaxp_pkg::dmaxp_mreq_s next_mreq;
    logic next_aw_hold, next_w_hold, next_bvalid, next_rvalid;
    logic [7:0] next_aw_addr;
    logic [31:0] next_w_data, next_rdata;
    logic [3:0] next_w_strb;
    logic [1:0] next_bresp, next_rresp;

    // Derived sizes and addresses; a size field of zero means the largest size.
    logic xm, en, aen, pattern_match_enable, blk_done, cell_done, match, wr_fire, rd_fire;
    logic [8:0] ssz9, dsz9, csz9;
    logic [16:0] blk_size, moved;
    logic [15:0] xptr;
    logic [31:0] src_addr, dst_addr;
    assign xm = ctrl[dmaxp_pkg::CTRL_XM];
    assign en = ctrl[dmaxp_pkg::CTRL_EN];
    assign aen = ctrl[dmaxp_pkg::CTRL_AEN];
    assign pattern_match_enable = econ[dmaxp_pkg::ECON_PATTERN_MATCH_ENABLE];
    assign ssz9 = (ssiz == 8'h00) ? dmaxp_pkg::NORM_MAX : {1'b0, ssiz};
    assign dsz9 = (dsiz == 8'h00) ? dmaxp_pkg::NORM_MAX : {1'b0, dsiz};
    assign csz9 = (csiz == 8'h00) ? dmaxp_pkg::NORM_MAX : {1'b0, csiz};
    assign xptr = {sptr, dptr};
    assign blk_size = xm ? (({ssiz, dsiz} == 16'h0000) ? dmaxp_pkg::EXT_MAX : {1'b0, ssiz, dsiz})
                         : {8'h00, (ssz9 > dsz9) ? ssz9 : dsz9};
    assign src_addr = xm ? ssa + {16'h0000, xptr} : ssa + {24'h000000, sptr};
    assign dst_addr = xm ? dsa + {16'h0000, xptr} : dsa + {24'h000000, dptr};
    assign moved = bcnt + 17'h00001;
    assign blk_done = (moved == blk_size);
    assign cell_done = xm ? blk_done : ({1'b0, cptr} + 9'h001 == csz9);
    assign wr_fire = aw_hold && w_hold && !s_axi_bvalid;
    assign rd_fire = s_axi_arvalid && s_axi_arready;

    // Byte-lane compare of the word being written; only enabled lanes count.
    always_comb begin
        match = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (mreq.be[i] && mreq.wdata[8*i +: 8] == pat) begin
                match = 1'b1;
            end
        end
        match = match && pattern_match_enable && mreq.we;
    end

    // Byte-strobe merge for register writes.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = val[8*i +: 8];
            end
        end
        return res;
    endfunction

    // Next-state logic for bus slave, registers and the transfer engine.
    always_comb begin
        logic [31:0] wv;
        wv = merge(dmaxp_pkg::RST_WORD, w_data, w_strb);
        next_ctrl = ctrl;
        next_econ = econ;
        next_flags = flags;
        next_ssiz = ssiz;
        next_dsiz = dsiz;
        next_csiz = csiz;
        next_sptr = sptr;
        next_dptr = dptr;
        next_cptr = cptr;
        next_pat = pat;
        next_rbyte = rbyte;
        next_ssa = ssa;
        next_dsa = dsa;
        next_bcnt = bcnt;
        next_start_pend = start_pend;
        next_abort_pend = abort_pend;
        next_state = state;
        next_mreq = mreq;
        next_aw_hold = aw_hold || (s_axi_awvalid && s_axi_awready);
        next_aw_addr = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_addr;
        next_w_hold = w_hold || (s_axi_wvalid && s_axi_wready);
        next_w_data = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : w_data;
        next_w_strb = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : w_strb;
        next_bvalid = s_axi_bvalid && !s_axi_bready;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid && !s_axi_rready;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        // Register writes; the force and abort bits act and are not stored.
        if (wr_fire) begin
            next_aw_hold = 1'b0;
            next_w_hold = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = dmaxp_pkg::RESP_OKAY;
            case (aw_addr)
                dmaxp_pkg::OFS_CTRL: next_ctrl = wv[7:0] & 8'h98;
                dmaxp_pkg::OFS_ECON: begin
                    next_econ = wv[7:0] & 8'h20;
                    if (wv[dmaxp_pkg::ECON_FORCE] && en) next_start_pend = 1'b1;
                    if (wv[dmaxp_pkg::ECON_ABORT]) next_abort_pend = 1'b1;
                end
                dmaxp_pkg::OFS_INT: next_flags = flags & ~(wv[7:0]);
                dmaxp_pkg::OFS_SSA: begin
                    next_ssa = merge(ssa, w_data, w_strb);
                    next_sptr = dmaxp_pkg::RST_BYTE;
                end
                dmaxp_pkg::OFS_DSA: begin
                    next_dsa = merge(dsa, w_data, w_strb);
                    next_dptr = dmaxp_pkg::RST_BYTE;
                end
                dmaxp_pkg::OFS_SSIZ: next_ssiz = wv[7:0];
                dmaxp_pkg::OFS_DSIZ: next_dsiz = wv[7:0];
                dmaxp_pkg::OFS_CSIZ: next_csiz = wv[7:0];
                dmaxp_pkg::OFS_PAT: next_pat = wv[7:0];
                dmaxp_pkg::OFS_SPTR, dmaxp_pkg::OFS_DPTR, dmaxp_pkg::OFS_CPTR: ;
                default: next_bresp = dmaxp_pkg::RESP_SLVERR;
            endcase
        end
        if (start_event && en) begin
            next_start_pend = 1'b1;
        end
        // Transfer engine; hardware sets land after software clears, so sets win.
        case (state)
            dmaxp_pkg::ST_IDLE: begin
                if (abort_pend) begin
                    next_abort_pend = 1'b0;
                    next_start_pend = 1'b0;
                    next_flags[dmaxp_pkg::INT_TAF] = 1'b1;
                    next_ctrl[dmaxp_pkg::CTRL_EN] = 1'b0;
                    next_sptr = dmaxp_pkg::RST_BYTE;
                    next_dptr = dmaxp_pkg::RST_BYTE;
                    next_cptr = dmaxp_pkg::RST_BYTE;
                    next_bcnt = 17'h00000;
                end else if (en && start_pend) begin
                    next_state = dmaxp_pkg::ST_READ;
                    next_mreq = '{req: 1'b1, we: 1'b0, addr: src_addr, wdata: 32'h0000_0000,
                                  be: 4'h1 << src_addr[1:0]};
                end
            end
            dmaxp_pkg::ST_READ: begin
                if (mrsp.ack) begin
                    if (mrsp.err) begin
                        next_state = dmaxp_pkg::ST_IDLE;
                        next_mreq.req = 1'b0;
                        next_flags[dmaxp_pkg::INT_AEF] = 1'b1;
                        next_ctrl[dmaxp_pkg::CTRL_EN] = 1'b0;
                        next_start_pend = 1'b0;
                    end else begin
                        next_state = dmaxp_pkg::ST_WRITE;
                        next_rbyte = mrsp.rdata[8*mreq.addr[1:0] +: 8];
                        next_mreq = '{req: 1'b1, we: 1'b1, addr: dst_addr,
                                      wdata: {4{mrsp.rdata[8*mreq.addr[1:0] +: 8]}},
                                      be: 4'h1 << dst_addr[1:0]};
                    end
                end
            end
            dmaxp_pkg::ST_WRITE: begin
                if (mrsp.ack) begin
                    next_mreq.req = 1'b0;
                    next_state = dmaxp_pkg::ST_IDLE;
                    next_bcnt = moved;
                    next_cptr = cptr + 8'h01;
                    if (xm) begin
                        {next_sptr, next_dptr} = xptr + 16'h0001;
                    end else begin
                        next_sptr = ({1'b0, sptr} + 9'h001 == ssz9) ? 8'h00 : sptr + 8'h01;
                        next_dptr = ({1'b0, dptr} + 9'h001 == dsz9) ? 8'h00 : dptr + 8'h01;
                    end
                    if (mrsp.err) begin
                        next_flags[dmaxp_pkg::INT_AEF] = 1'b1;
                        next_ctrl[dmaxp_pkg::CTRL_EN] = 1'b0;
                        next_start_pend = 1'b0;
                    end else if (blk_done || match) begin
                        next_flags[dmaxp_pkg::INT_BCF] = 1'b1;
                        if (!aen) next_ctrl[dmaxp_pkg::CTRL_EN] = 1'b0;
                        next_sptr = dmaxp_pkg::RST_BYTE;
                        next_dptr = dmaxp_pkg::RST_BYTE;
                        next_cptr = dmaxp_pkg::RST_BYTE;
                        next_bcnt = 17'h00000;
                        next_start_pend = 1'b0;
                    end else if (abort_pend) begin
                        next_state = dmaxp_pkg::ST_IDLE;
                    end else if (cell_done) begin
                        next_cptr = dmaxp_pkg::RST_BYTE;
                        next_start_pend = 1'b0;
                    end else begin
                        next_state = dmaxp_pkg::ST_READ;
                        next_mreq = '{req: 1'b1, we: 1'b0, addr: next_src(), wdata: 32'h0,
                                      be: 4'h1 << next_src_lo()};
                    end
                end
            end
            default: next_state = dmaxp_pkg::ST_IDLE;
        endcase
        // Register reads answer one cycle after the address is taken.
        if (rd_fire) begin
            next_rvalid = 1'b1;
            next_rresp = dmaxp_pkg::RESP_OKAY;
            case (s_axi_araddr)
                dmaxp_pkg::OFS_CTRL: next_rdata = {24'h0, ctrl};
                dmaxp_pkg::OFS_ECON: next_rdata = {24'h0, econ};
                dmaxp_pkg::OFS_INT: next_rdata = {24'h0, flags};
                dmaxp_pkg::OFS_SSA: next_rdata = ssa;
                dmaxp_pkg::OFS_DSA: next_rdata = dsa;
                dmaxp_pkg::OFS_SSIZ: next_rdata = {24'h0, ssiz};
                dmaxp_pkg::OFS_DSIZ: next_rdata = {24'h0, dsiz};
                dmaxp_pkg::OFS_SPTR: next_rdata = {24'h0, sptr};
                dmaxp_pkg::OFS_DPTR: next_rdata = xm ? {16'h0, xptr} : {24'h0, dptr};
                dmaxp_pkg::OFS_CSIZ: next_rdata = {24'h0, csiz};
                dmaxp_pkg::OFS_CPTR: next_rdata = {24'h0, cptr};
                dmaxp_pkg::OFS_PAT: next_rdata = {24'h0, pat};
                default: begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = dmaxp_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    // Source address of the following transaction, from the pointers about to be stored.
    function automatic logic [31:0] next_src();
        return xm ? ssa + {16'h0000, xptr + 16'h0001}
                  : ssa + {24'h000000, ({1'b0, sptr} + 9'h001 == ssz9) ? 8'h00 : sptr + 8'h01};
    endfunction
    function automatic logic [1:0] next_src_lo();
        logic [31:0] a;
        a = next_src();
        return a[1:0];
    endfunction

    // State registers; the strobe merge for 8-bit registers starts from zero.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= dmaxp_pkg::RST_BYTE;
            econ <= dmaxp_pkg::RST_BYTE;
            flags <= dmaxp_pkg::RST_BYTE;
            ssiz <= dmaxp_pkg::RST_BYTE;
            dsiz <= dmaxp_pkg::RST_BYTE;
            csiz <= dmaxp_pkg::RST_BYTE;
            sptr <= dmaxp_pkg::RST_BYTE;
            dptr <= dmaxp_pkg::RST_BYTE;
            cptr <= dmaxp_pkg::RST_BYTE;
            pat <= dmaxp_pkg::RST_BYTE;
            rbyte <= dmaxp_pkg::RST_BYTE;
            ssa <= dmaxp_pkg::RST_WORD;
            dsa <= dmaxp_pkg::RST_WORD;
            bcnt <= 17'h00000;
            start_pend <= 1'b0;
            abort_pend <= 1'b0;
            state <= dmaxp_pkg::ST_IDLE;
            mreq <= '0;
            aw_hold <= 1'b0;
            aw_addr <= 8'h00;
            w_hold <= 1'b0;
            w_data <= dmaxp_pkg::RST_WORD;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= dmaxp_pkg::RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= dmaxp_pkg::RST_WORD;
            s_axi_rresp <= dmaxp_pkg::RESP_OKAY;
        end else begin
            ctrl <= next_ctrl;
            econ <= next_econ;
            flags <= next_flags;
            ssiz <= next_ssiz;
            dsiz <= next_dsiz;
            csiz <= next_csiz;
            sptr <= next_sptr;
            dptr <= next_dptr;
            cptr <= next_cptr;
            pat <= next_pat;
            rbyte <= next_rbyte;
            ssa <= next_ssa;
            dsa <= next_dsa;
            bcnt <= next_bcnt;
            start_pend <= next_start_pend;
            abort_pend <= next_abort_pend;
            state <= next_state;
            mreq <= next_mreq;
            aw_hold <= next_aw_hold;
            aw_addr <= next_aw_addr;
            w_hold <= next_w_hold;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_awready <= !next_aw_hold;
            s_axi_wready <= !next_w_hold;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= !next_rvalid;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end

    // Checks on the transfer engine.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic wr_end, int_wr;
    assign wr_end = (state == dmaxp_pkg::ST_WRITE) && mrsp.ack && !mrsp.err;
    assign int_wr = wr_fire && (aw_addr == dmaxp_pkg::OFS_INT);
    property p_match_stop;
        wr_end && match && !aen |=> !en && flags[dmaxp_pkg::INT_BCF];
    endproperty
    a_match_stop: assert property (p_match_stop) else $error("match did not stop channel");
    property p_match_auto;
        wr_end && match && aen && !wr_fire |=> en;
    endproperty
    a_match_auto: assert property (p_match_auto) else $error("auto-enable lost");
    property p_match_ptr;
        wr_end && match |=> sptr == 8'h00 && dptr == 8'h00 && state == dmaxp_pkg::ST_IDLE;
    endproperty
    a_match_ptr: assert property (p_match_ptr) else $error("pointers not reset");
    property p_no_pattern_match_enable;
        wr_end && !pattern_match_enable && !blk_done && !int_wr |=> $stable(flags[dmaxp_pkg::INT_BCF]);
    endproperty
    a_no_pattern_match_enable: assert property (p_no_pattern_match_enable) else $error("flag set without match");
    property p_start;
        state == dmaxp_pkg::ST_IDLE && en && start_pend && !abort_pend
            |=> state == dmaxp_pkg::ST_READ && mreq.req && !mreq.we;
    endproperty
    a_start: assert property (p_start) else $error("enabled start ignored");
    property p_disabled;
        state == dmaxp_pkg::ST_IDLE && !en |=> state == dmaxp_pkg::ST_IDLE;
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled channel moved");
    property p_flag_hold;
        flags[dmaxp_pkg::INT_BCF] && !int_wr |=> flags[dmaxp_pkg::INT_BCF];
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("complete flag dropped");
    property p_abort_finish;
        state == dmaxp_pkg::ST_READ && abort_pend && mrsp.ack && !mrsp.err
            |=> state == dmaxp_pkg::ST_WRITE ##[1:1000] state == dmaxp_pkg::ST_IDLE;
    endproperty
    a_abort_finish: assert property (p_abort_finish) else $error("abort cut transaction");
    property p_ext_ptr;
        wr_end && xm && !blk_done && !match |=> xptr == $past(xptr) + 16'h0001;
    endproperty
    a_ext_ptr: assert property (p_ext_ptr) else $error("joined pointer wrong");
    property p_ext_cell;
        wr_end && xm && !blk_done && !match && !abort_pend |=> state == dmaxp_pkg::ST_READ;
    endproperty
    a_ext_cell: assert property (p_ext_cell) else $error("extended block split");
    c_match: cover property (wr_end && match);
    c_ext_done: cover property (wr_end && xm && blk_done);
    c_abort: cover property (abort_pend && state == dmaxp_pkg::ST_WRITE);

endmodule // dmaxp_channel
`default_nettype wire

// >>> verif/dmaxp_mem_model.sv
// Byte-wide memory model that answers the channel's system-bus transactions.
`timescale 1ns/1ns
`default_nettype none
module dmaxp_mem_model (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // System bus from the channel.
    input wire dmaxp_pkg::dmaxp_mreq_s mreq,
    output dmaxp_pkg::dmaxp_mrsp_s mrsp
);
    logic [7:0] mem [256];
    logic tog;
    // Each location holds its own address, so copies are easy to predict.
    initial for (int i = 0; i < 256; i++) mem[i] = 8'(i);
    // A phase bit makes some answers prompt and some late; idle read data keeps toggling.
    always @(posedge aclk) begin
        tog <= aresetn & ~tog;
        mrsp <= {2'b00, ~mrsp.rdata};
        if (!aresetn) mrsp <= '0;
        else if (mreq.req && !mrsp.ack && tog) begin
            mrsp.ack <= 1'b1;
            if (mreq.we) mem[mreq.addr[7:0]] <= mreq.wdata[7:0];
            else mrsp.rdata <= {4{mem[mreq.addr[7:0]]}};
        end
    end
endmodule // dmaxp_mem_model
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench: extended, normal and pattern-terminated transfers.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic aclk = 1'b0, aresetn = 1'b0, aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0;
    logic ar_valid = 1'b0, r_ready = 1'b0, start_event = 1'b0;
    logic [7:0] aw_addr = 8'h00, ar_addr = 8'h00;
    logic [31:0] w_data = 32'h0, r_data, d;
    logic [1:0] b_resp, r_resp, resp;
    logic aw_ready, w_ready, b_valid, ar_ready, r_valid;
    dmaxp_pkg::dmaxp_mreq_s mreq;
    dmaxp_pkg::dmaxp_mrsp_s mrsp;
    int num_errors = 0, num_checks = 0, cyc = 0;
    dmaxp_channel i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw_addr),
        .s_axi_awvalid(aw_valid), .s_axi_awready(aw_ready), .s_axi_wdata(w_data),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(w_valid), .s_axi_wready(w_ready),
        .s_axi_bresp(b_resp), .s_axi_bvalid(b_valid), .s_axi_bready(b_ready),
        .s_axi_araddr(ar_addr), .s_axi_arvalid(ar_valid), .s_axi_arready(ar_ready),
        .s_axi_rdata(r_data), .s_axi_rresp(r_resp), .s_axi_rvalid(r_valid),
        .s_axi_rready(r_ready), .start_event(start_event), .mreq(mreq), .mrsp(mrsp));
    dmaxp_mem_model i_mem (.aclk(aclk), .aresetn(aresetn), .mreq(mreq), .mrsp(mrsp));
    // The cycle ceiling turns a hang into a failure.
    initial forever #50 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            end_sim();
        end
    end
    task automatic chk(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    // Address and data are offered together and each is dropped once taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        aw_addr <= a; w_data <= v; aw_valid <= 1'b1; w_valid <= 1'b1; b_ready <= 1'b1;
        do begin
            @(posedge aclk);
            if (aw_ready) aw_valid <= 1'b0;
            if (w_ready) w_valid <= 1'b0;
        end while (b_valid !== 1'b1);
        b_ready <= 1'b0; resp = b_resp;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        ar_addr <= a; ar_valid <= 1'b1; r_ready <= 1'b1;
        do begin
            @(posedge aclk);
            if (ar_ready) ar_valid <= 1'b0;
        end while (r_valid !== 1'b1);
        r_ready <= 1'b0; d = r_data; resp = r_resp;
    endtask
    task automatic cfg(input logic [31:0] c, e, p, sa, da, ss, ds);
        wr(dmaxp_pkg::OFS_CTRL, c); wr(dmaxp_pkg::OFS_ECON, e); wr(dmaxp_pkg::OFS_PAT, p);
        wr(dmaxp_pkg::OFS_SSA, sa); wr(dmaxp_pkg::OFS_DSA, da); wr(dmaxp_pkg::OFS_SSIZ, ss);
        wr(dmaxp_pkg::OFS_DSIZ, ds); wr(dmaxp_pkg::OFS_CSIZ, ds); wr(dmaxp_pkg::OFS_INT, 32'hb);
        wr(dmaxp_pkg::OFS_CTRL, c | 32'h80);
    endtask
    task automatic wait_done();
        d = 32'h0;
        while (d[3] !== 1'b1) rd(dmaxp_pkg::OFS_INT);
    endtask
    // Extended size 0x0100 bytes, cut short by the pattern in source byte 5.
    task automatic t_ext();
        cfg(32'h08, 32'h20, 32'h05, 32'h00, 32'h80, 32'h01, 32'h00);
        wr(dmaxp_pkg::OFS_ECON, 32'ha0);
        wait_done();
        for (int i = 0; i < 7; i++) chk(i_mem.mem[8'h80 + i] === 8'(i < 6 ? i : 134), "copy");
        rd(dmaxp_pkg::OFS_CTRL); chk(d[7] === 1'b0, "enable kept");
        rd(dmaxp_pkg::OFS_DPTR); chk(d === 32'h0, "pointer");
        rd(dmaxp_pkg::OFS_INT); chk(d[3] === 1'b1, "flag lost");
        $display("test extended pattern done");
    endtask
    // Normal mode, pattern present in data but disabled, auto-enable on.
    task automatic t_norm();
        cfg(32'h10, 32'h00, 32'h11, 32'h10, 32'ha0, 32'h04, 32'h04);
        @(posedge aclk); start_event <= 1'b1;
        @(posedge aclk); start_event <= 1'b0;
        wait_done();
        for (int i = 0; i < 5; i++) chk(i_mem.mem[8'ha0 + i] === 8'(i < 4 ? 16 + i : 164), "blk");
        rd(dmaxp_pkg::OFS_CTRL); chk(d[7] === 1'b1, "auto-enable");
        wr(dmaxp_pkg::OFS_INT, 32'h8); rd(dmaxp_pkg::OFS_INT); chk(d[3] === 1'b0, "clear");
        $display("test normal block done");
    endtask
    // Extended block of 0x0200 bytes, aborted once the joined pointer has passed 0x00ff.
    // It overwrites the whole memory, so it runs after the tests that check memory.
    task automatic t_abort();
        cfg(32'h08, 32'h00, 32'h00, 32'h00, 32'h80, 32'h02, 32'h00);
        wr(dmaxp_pkg::OFS_ECON, 32'h80);
        d = 32'h0;
        while (d[15:8] !== 8'h01) rd(dmaxp_pkg::OFS_DPTR);
        rd(dmaxp_pkg::OFS_SPTR); chk(d === 32'h1, "source pointer high byte");
        wr(dmaxp_pkg::OFS_ECON, 32'h40);
        d = 32'h0;
        while (d[1] !== 1'b1) rd(dmaxp_pkg::OFS_INT);
        chk(d[3] === 1'b0, "abort flagged completion");
        rd(dmaxp_pkg::OFS_CTRL); chk(d[7] === 1'b0, "enable kept after abort");
        rd(dmaxp_pkg::OFS_DPTR); chk(d === 32'h0, "pointer after abort");
        $display("test extended abort done");
    endtask
    task automatic t_bad();
        wr(8'h30, 32'h1); chk(resp === dmaxp_pkg::RESP_SLVERR, "write resp");
        rd(8'h30); chk(d === 32'h0 && resp === dmaxp_pkg::RESP_SLVERR, "read resp");
        $display("test unmapped done");
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_ext(); t_norm(); t_abort(); t_bad(); end_sim();
    end
endmodule // testbench
`default_nettype wire
